// ---- modem_seq_consts.svh ----
`ifndef MODEM_SEQ_CONSTS_SVH
`define MODEM_SEQ_CONSTS_SVH

// ----------------------------------------
// Register addresses (7-bit)
// ----------------------------------------
`define A_BUF_DATA      7'h00
`define A_OP_MODE       7'h01
`define A_CARRIER_HI    7'h06
`define A_CARRIER_MID   7'h07
`define A_CARRIER_LO    7'h08
`define A_BUF_PTR       7'h0d
`define A_TX_START      7'h0e
`define A_RX_START      7'h0f
`define A_RX_LAST_PKT   7'h10
`define A_EVENT_FLAGS   7'h12
`define A_RX_NB_BYTES   7'h13
`define A_RX_WR_ADDR    7'h25
`define A_WINDOW_HI     7'h1e
`define A_WINDOW_LO     7'h1f
`define A_PREAMBLE_HI   7'h20
`define A_PREAMBLE_LO   7'h21
`define A_TX_COUNT      7'h22
`define A_DRIFT_COMP    7'h27
`define A_OFFSET_HI     7'h28
`define A_OFFSET_MID    7'h29
`define A_OFFSET_LO     7'h2a

// ----------------------------------------
// Operating mode codes
// ----------------------------------------
`define MODE_SLEEP      3'h0
`define MODE_STDBY      3'h1
`define MODE_TX_SYNTH   3'h2
`define MODE_TX         3'h3
`define MODE_RX_SYNTH   3'h4
`define MODE_RX_CONT    3'h5
`define MODE_RX_ONESHOT 3'h6

// ----------------------------------------
// Event flag bit positions
// ----------------------------------------
`define FLG_WINDOW_EXP  7
`define FLG_RX_DONE     6
`define FLG_CHECK_FAIL  5
`define FLG_HEADER_OK   4
`define FLG_TX_DONE     3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_TX_START    8'h80
`define RST_RX_START    8'h00
`define RST_WINDOW      10'h064
`define RST_PREAMBLE    16'h0008
`define RST_TX_COUNT    8'h01
`define RST_CARRIER     24'h400000
`define RST_DRIFT       8'h00

`endif

// ---- modem_seq_pkg.sv ----
package modem_seq_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_TX,
    SEQ_SEARCH,
    SEQ_PREAMBLE,
    SEQ_PAYLOAD
  } seq_state_t;

  // Events from the demodulator, one-cycle pulses on clk_sys
  typedef struct packed {
    logic       sym_tick;
    logic       preamble_det;
    logic       header_ok;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       payload_end;
    logic       crc_bad;
    logic       signal_lost;
  } demod_ev_t;

endpackage : modem_seq_pkg

// ---- spread_modem_mode_sequencer.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "modem_seq_consts.svh"

module spread_modem_mode_sequencer
  import modem_seq_pkg::*;
#(
  parameter int BUF_DEPTH = 256
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        spi_nss_n,
  input  wire logic        spi_sck,
  input  wire logic        spi_mosi,
  output var  logic        spi_miso,
  output var  logic        spi_miso_oe_n,
  input  wire demod_ev_t   demod,
  input  wire logic [19:0] freq_offset_value,
  input  wire logic        tx_byte_req,
  input  wire logic        tx_end,
  output var  logic [7:0]  tx_byte,
  output var  logic        tx_byte_valid,
  output var  logic        rx_gain_set,
  output var  logic [2:0]  op_mode,
  output var  logic [23:0] carrier_freq_word,
  output var  logic [7:0]  drift_comp_value
);

  // ----------------------------------------
  // Serial port synchronisers
  // ----------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       sck_prev_q;

  // Two flops on each pin; only sync2 is read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_q    <= 3'h4; // Pin idle levels: deselected, clock low
      sync2_q    <= 3'h4;
      sck_prev_q <= 1'b0;
    end else begin
      sync1_q    <= {spi_nss_n, spi_sck, spi_mosi};
      sync2_q    <= sync1_q;
      sck_prev_q <= sync2_q[1];
    end
  end

  wire logic sel_w  = ~sync2_q[2];
  wire logic rise_w = sel_w & sync2_q[1] & ~sck_prev_q;
  wire logic fall_w = sel_w & ~sync2_q[1] & sck_prev_q;

  // ----------------------------------------
  // Serial frame decode
  // ----------------------------------------
  logic [2:0] bit_cnt_q;
  logic [6:0] sh_in_q;
  logic       first_q;
  logic       wnr_q;
  logic [6:0] addr_q;
  logic [7:0] out_q;

  wire logic [7:0] in_byte_w   = {sh_in_q, sync2_q[0]};
  wire logic       byte_done_w = rise_w & (bit_cnt_q == 3'h7);
  wire logic       hdr_done_w  = byte_done_w & first_q;
  wire logic       data_done_w = byte_done_w & ~first_q;
  wire logic       reg_wr_w    = data_done_w & wnr_q;
  wire logic       rd_load_w   = (hdr_done_w & ~in_byte_w[7]) | (data_done_w & ~wnr_q);
  // Burst address walks up, except on the buffer data port
  wire logic [6:0] addr_next_w = (addr_q == `A_BUF_DATA) ? addr_q : addr_q + 7'h01;
  wire logic [6:0] rd_addr_w   = hdr_done_w ? in_byte_w[6:0] : addr_next_w;

  // ----------------------------------------
  // Register and sequencer state
  // ----------------------------------------
  logic [2:0]  mode_q;
  logic [2:0]  mode_prev_q;
  seq_state_t  state_q;
  logic [7:0]  flags_q;
  logic [7:0]  buf_ptr_q;
  logic [7:0]  tx_start_q;
  logic [7:0]  rx_start_q;
  logic [7:0]  tx_count_q;
  logic [9:0]  window_q;
  logic [15:0] preamble_q;
  logic [23:0] carrier_q;
  logic [7:0]  drift_q;
  logic [19:0] offset_q;
  logic [7:0]  rx_wptr_q;
  logic [7:0]  pkt_start_q;
  logic [7:0]  rx_last_q;
  logic [7:0]  rx_nb_q;
  logic [7:0]  rx_cnt_q;
  logic [9:0]  win_cnt_q;
  logic [15:0] pre_cnt_q;
  logic [7:0]  tx_idx_q;
  logic [7:0]  mem_q [BUF_DEPTH];

  // Buffer fetch for readout; a data byte already sent moves one ahead
  wire logic [7:0] fifo_rd_idx_w = buf_ptr_q + {7'h00, data_done_w};

  // Register readout; sleep keeps the buffer unreadable
  function automatic logic [7:0] rd_mux(input logic [6:0] a);
    case (a)
      `A_BUF_DATA:    rd_mux = (mode_q == `MODE_SLEEP) ? 8'h00 : mem_q[fifo_rd_idx_w];
      `A_OP_MODE:     rd_mux = {5'h00, mode_q};
      `A_CARRIER_HI:  rd_mux = carrier_q[23:16];
      `A_CARRIER_MID: rd_mux = carrier_q[15:8];
      `A_CARRIER_LO:  rd_mux = carrier_q[7:0];
      `A_BUF_PTR:     rd_mux = buf_ptr_q;
      `A_TX_START:    rd_mux = tx_start_q;
      `A_RX_START:    rd_mux = rx_start_q;
      `A_RX_LAST_PKT: rd_mux = rx_last_q;
      `A_EVENT_FLAGS: rd_mux = flags_q;
      `A_RX_NB_BYTES: rd_mux = rx_nb_q;
      `A_RX_WR_ADDR:  rd_mux = rx_wptr_q;
      `A_WINDOW_HI:   rd_mux = {6'h00, window_q[9:8]};
      `A_WINDOW_LO:   rd_mux = window_q[7:0];
      `A_PREAMBLE_HI: rd_mux = preamble_q[15:8];
      `A_PREAMBLE_LO: rd_mux = preamble_q[7:0];
      `A_TX_COUNT:    rd_mux = tx_count_q;
      `A_DRIFT_COMP:  rd_mux = drift_q;
      `A_OFFSET_HI:   rd_mux = {4'h0, offset_q[19:16]};
      `A_OFFSET_MID:  rd_mux = offset_q[15:8];
      `A_OFFSET_LO:   rd_mux = offset_q[7:0];
      default:        rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  // Frame shifter; a read header or a read data byte loads the next byte out
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !sel_w) begin
      bit_cnt_q <= 3'h0;
      sh_in_q   <= 7'h00;
      first_q   <= 1'b1;
      wnr_q     <= 1'b0;
      addr_q    <= 7'h00;
      out_q     <= 8'h00;
    end else if (rise_w) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      sh_in_q   <= in_byte_w[6:0];
      if (hdr_done_w) begin
        first_q <= 1'b0;
        wnr_q   <= in_byte_w[7];
        addr_q  <= in_byte_w[6:0];
      end else if (data_done_w) begin
        addr_q  <= addr_next_w;
      end
      if (rd_load_w) begin
        out_q   <= rd_mux(rd_addr_w);
      end
    end
  end

  // Data out changes on the falling edge, held off while deselected
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      spi_miso      <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      spi_miso_oe_n <= ~sel_w;
      if (fall_w) begin
        spi_miso    <= out_q[3'h7 - bit_cnt_q];
      end
    end
  end

  // ----------------------------------------
  // Write decode and access gating
  // ----------------------------------------
  wire logic mode_wr_w   = reg_wr_w & (addr_q == `A_OP_MODE);
  wire logic cfg_ok_w    = (mode_q == `MODE_SLEEP) | (mode_q == `MODE_STDBY) |
                           (mode_q == `MODE_TX_SYNTH) | (mode_q == `MODE_RX_SYNTH);
  wire logic cfg_wr_w    = reg_wr_w & cfg_ok_w;
  // Buffer fill outside standby is dropped so a running receive is never hit
  wire logic buf_wr_w    = reg_wr_w & (addr_q == `A_BUF_DATA) & (mode_q == `MODE_STDBY);
  wire logic buf_rd_w    = data_done_w & ~wnr_q & (addr_q == `A_BUF_DATA) &
                           (mode_q != `MODE_SLEEP);
  wire logic mode_stable = (mode_q == mode_prev_q) & ~mode_wr_w;
  wire logic one_shot_w  = (mode_q == `MODE_RX_ONESHOT);
  wire logic cont_w      = (mode_q == `MODE_RX_CONT);

  // ----------------------------------------
  // Sequencer events
  // ----------------------------------------
  wire logic in_tx_w   = mode_stable & (state_q == SEQ_TX);
  wire logic in_srch_w = mode_stable & (state_q == SEQ_SEARCH);
  wire logic in_pre_w  = mode_stable & (state_q == SEQ_PREAMBLE);
  wire logic in_pay_w  = mode_stable & (state_q == SEQ_PAYLOAD);
  wire logic [9:0] win_next_w  = win_cnt_q + 10'h001;
  wire logic [15:0] pre_next_w = pre_cnt_q + 16'h0001;
  // Window counts only while searching; a packet under way expires only on signal loss in one-shot
  wire logic win_exp_w  = in_srch_w & one_shot_w & demod.sym_tick &
                          (win_next_w >= window_q);
  wire logic lost_w     = (in_pre_w | in_pay_w) & demod.signal_lost;
  wire logic ev_expire  = win_exp_w | (lost_w & one_shot_w);
  wire logic ev_header  = in_pre_w & demod.header_ok;
  wire logic ev_receive_complete_flag  = in_pay_w & demod.payload_end;
  wire logic ev_chkfail = ev_receive_complete_flag & demod.crc_bad;
  wire logic ev_transmit_complete_flag  = in_tx_w & tx_end;
  wire logic pre_long_w = in_pre_w & cont_w & demod.sym_tick & ~demod.header_ok &
                          (pre_next_w > preamble_q);
  wire logic auto_stdby = ev_transmit_complete_flag | ev_expire | (ev_receive_complete_flag & one_shot_w);

  wire logic [7:0] flag_set_w = {ev_expire, ev_receive_complete_flag, ev_chkfail, ev_header, ev_transmit_complete_flag, 3'h0};
  wire logic [7:0] flag_clr_w = (reg_wr_w & (addr_q == `A_EVENT_FLAGS)) ? in_byte_w : 8'h00;

  // Sticky flags, write one to clear; a new event wins over its clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= (flags_q & ~flag_clr_w) | flag_set_w;
    end
  end

  // Operating mode: host write first, else automatic return to standby
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_q      <= `MODE_STDBY;
      mode_prev_q <= `MODE_STDBY;
    end else begin
      mode_prev_q <= mode_q;
      if (mode_wr_w) begin
        mode_q    <= in_byte_w[2:0];
      end else if (auto_stdby) begin
        mode_q    <= `MODE_STDBY;
      end
    end
  end

  // Static configuration and pointers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      buf_ptr_q  <= 8'h00;
      tx_start_q <= `RST_TX_START;
      rx_start_q <= `RST_RX_START;
      tx_count_q <= `RST_TX_COUNT;
      window_q   <= `RST_WINDOW;
      preamble_q <= `RST_PREAMBLE;
      carrier_q  <= `RST_CARRIER;
      drift_q    <= `RST_DRIFT;
    end else begin
      if (reg_wr_w && addr_q == `A_BUF_PTR) begin
        buf_ptr_q <= in_byte_w;
      end else if (buf_wr_w || buf_rd_w) begin
        buf_ptr_q <= buf_ptr_q + 8'h01;
      end
      if (cfg_wr_w) begin
        case (addr_q)
          `A_TX_START:    tx_start_q        <= in_byte_w;
          `A_RX_START:    rx_start_q        <= in_byte_w;
          `A_TX_COUNT:    tx_count_q        <= in_byte_w;
          `A_WINDOW_HI:   window_q[9:8]     <= in_byte_w[1:0];
          `A_WINDOW_LO:   window_q[7:0]     <= in_byte_w;
          `A_PREAMBLE_HI: preamble_q[15:8]  <= in_byte_w;
          `A_PREAMBLE_LO: preamble_q[7:0]   <= in_byte_w;
          `A_CARRIER_HI:  carrier_q[23:16]  <= in_byte_w;
          `A_CARRIER_MID: carrier_q[15:8]   <= in_byte_w;
          `A_CARRIER_LO:  carrier_q[7:0]    <= in_byte_w;
          `A_DRIFT_COMP:  drift_q           <= in_byte_w;
          default:        ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q     <= SEQ_IDLE;
      win_cnt_q   <= 10'h000;
      pre_cnt_q   <= 16'h0000;
      rx_wptr_q   <= 8'h00;
      pkt_start_q <= 8'h00;
      rx_last_q   <= 8'h00;
      rx_nb_q     <= 8'h00;
      rx_cnt_q    <= 8'h00;
      tx_idx_q    <= 8'h00;
      offset_q    <= 20'h00000;
    end else if (mode_q != mode_prev_q) begin
      // Entry into a new mode restarts the state, window count and transmit and receive pointers, aborting what ran
      win_cnt_q   <= 10'h000;
      tx_idx_q    <= tx_start_q;
      rx_wptr_q   <= rx_start_q;
      case (mode_q)
        `MODE_TX:                       state_q <= SEQ_TX;
        `MODE_RX_CONT, `MODE_RX_ONESHOT: state_q <= SEQ_SEARCH;
        default:                        state_q <= SEQ_IDLE;
      endcase
    end else if (mode_stable) begin
      case (state_q)
        SEQ_TX: begin
          if (tx_byte_req) begin
            tx_idx_q <= tx_idx_q + 8'h01;
          end
          if (ev_transmit_complete_flag) begin
            state_q <= SEQ_IDLE;
          end
        end
        SEQ_SEARCH: begin
          if (demod.preamble_det) begin
            state_q   <= SEQ_PREAMBLE;
            pre_cnt_q <= 16'h0000;
          end else if (win_exp_w) begin
            state_q   <= SEQ_IDLE;
          end else if (demod.sym_tick && one_shot_w) begin
            win_cnt_q <= win_next_w;
          end
        end
        SEQ_PREAMBLE: begin
          if (ev_header) begin
            state_q     <= SEQ_PAYLOAD;
            pkt_start_q <= rx_wptr_q;
            rx_cnt_q    <= 8'h00;
            offset_q    <= freq_offset_value;
          end else if (pre_long_w) begin
            state_q     <= SEQ_SEARCH;
          end else if (lost_w) begin
            state_q     <= one_shot_w ? SEQ_IDLE : SEQ_SEARCH;
          end else if (demod.sym_tick) begin
            pre_cnt_q   <= pre_next_w;
          end
        end
        SEQ_PAYLOAD: begin
          if (demod.byte_valid) begin
            rx_wptr_q <= rx_wptr_q + 8'h01;
            rx_cnt_q  <= rx_cnt_q + 8'h01;
          end
          if (ev_receive_complete_flag) begin
            rx_last_q <= pkt_start_q;
            rx_nb_q   <= rx_cnt_q + {7'h00, demod.byte_valid};
            state_q   <= one_shot_w ? SEQ_IDLE : SEQ_SEARCH;
          end else if (lost_w) begin
            state_q   <= one_shot_w ? SEQ_IDLE : SEQ_SEARCH;
          end
        end
        default: state_q <= SEQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Packet buffer
  // ----------------------------------------
  wire logic rx_wr_w = in_pay_w & demod.byte_valid;
  wire logic sleep_entry_w = (mode_q == `MODE_SLEEP) & (mode_prev_q != `MODE_SLEEP);

  // Receiver writes even with a bad check; sleep wipes the whole buffer
  always_ff @(posedge clk_sys) begin
    if (sleep_entry_w) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (rx_wr_w) begin
      mem_q[rx_wptr_q] <= demod.byte_data;
    end else if (buf_wr_w) begin
      mem_q[buf_ptr_q] <= in_byte_w;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_byte           <= 8'h00;
      tx_byte_valid     <= 1'b0;
      rx_gain_set       <= 1'b0;
      op_mode           <= `MODE_STDBY;
      carrier_freq_word <= `RST_CARRIER;
      drift_comp_value  <= `RST_DRIFT;
    end else begin
      tx_byte_valid     <= in_tx_w & tx_byte_req;
      if (in_tx_w && tx_byte_req) begin
        tx_byte         <= mem_q[tx_idx_q];
      end
      rx_gain_set       <= in_srch_w & demod.preamble_det;
      op_mode           <= mode_q;
      // Synthesiser scales this word by crystal over two to nineteen
      carrier_freq_word <= carrier_q;
      drift_comp_value  <= drift_q;
    end
  end

endmodule : spread_modem_mode_sequencer
`default_nettype wire

// ---- spread_modem_mode_sequencer_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Port-level checks of the mode sequencer
// ----------------------------------------
module spread_modem_mode_sequencer_properties
  import modem_seq_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        spi_nss_n,
  input wire demod_ev_t   demod,
  input wire logic        tx_byte_req,
  input wire logic        tx_end,
  input wire logic        tx_byte_valid,
  input wire logic        rx_gain_set,
  input wire logic [2:0]  op_mode,
  input wire logic [23:0] carrier_freq_word,
  input wire logic [7:0]  drift_comp_value
);
  // One domain, so one clock and one reset serve every property
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_TX_ANSWER: assert property (
    tx_byte_valid |-> $past(tx_byte_req) && op_mode == 3'h3)
    else $error("tx byte without request in transmit");
  AST_TX_RETURN: assert property (
    tx_end && op_mode == 3'h3 && $past(op_mode) == 3'h3 |-> ##[1:3] op_mode == 3'h1)
    else $error("no return to standby after transmit");
  AST_GAIN_CAUSE: assert property (
    rx_gain_set |-> $past(demod.preamble_det))
    else $error("gain set without preamble");
  AST_GAIN_MODE: assert property (
    rx_gain_set |-> op_mode inside {3'h5, 3'h6})
    else $error("gain set outside receive");
  // Eight quiet cycles guarantee that no mode write is still landing
  AST_CONT_STAYS: assert property (
    (op_mode == 3'h5 && spi_nss_n) [*8] |=> op_mode == 3'h5)
    else $error("continuous receive left on its own");
  AST_CFG_GATE: assert property (
    $changed({carrier_freq_word, drift_comp_value}) |-> op_mode inside {3'h0, 3'h1, 3'h2, 3'h4})
    else $error("config changed in a locked mode");
  AST_RX_END: assert property (
    (demod.payload_end || demod.signal_lost) && op_mode == 3'h6 && $past(op_mode) == 3'h6
    |-> ##[1:3] op_mode == 3'h1)
    else $error("one-shot receive did not end in standby");
  AST_IDLE_QUIET: assert property (
    op_mode inside {3'h0, 3'h1} && $past(op_mode) inside {3'h0, 3'h1}
    |-> !tx_byte_valid && !rx_gain_set)
    else $error("activity while idle");
endmodule : spread_modem_mode_sequencer_properties

bind spread_modem_mode_sequencer spread_modem_mode_sequencer_properties
  spread_modem_mode_sequencer_properties_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .spi_nss_n(spi_nss_n), .demod(demod),
  .tx_byte_req(tx_byte_req), .tx_end(tx_end), .tx_byte_valid(tx_byte_valid),
  .rx_gain_set(rx_gain_set), .op_mode(op_mode), .carrier_freq_word(carrier_freq_word),
  .drift_comp_value(drift_comp_value));
`default_nettype wire

// ---- host_spi.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Host microcontroller on the serial port
// ----------------------------------------
module host_spi (
  input  wire logic clk_sys,
  output var  logic spi_nss_n,
  output var  logic spi_sck,
  output var  logic spi_mosi,
  input  wire logic spi_miso
);
  localparam int HALF = 8; // 80 ns, half of the 160 ns link clock

  // Deselected, clock parked low between frames
  initial begin
    spi_nss_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end

  // Two-byte frame, MSB first; mosi moves while sck is low, miso taken at the rise
  task automatic xfer(input logic [15:0] s, output logic [7:0] r);
    r = 8'h00;
    @(posedge clk_sys) spi_nss_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi <= s[i];
      repeat (HALF) @(posedge clk_sys);
      if (i < 8) r[i] = spi_miso;
      spi_sck <= 1'b1;
      repeat (HALF) @(posedge clk_sys);
      spi_sck <= 1'b0;
    end
    repeat (HALF) @(posedge clk_sys);
    spi_nss_n <= 1'b1;
    spi_mosi <= ~s[0]; // Stale data line must not look valid
    repeat (HALF) @(posedge clk_sys);
  endtask : xfer

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer({1'b1, a, d}, r);
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    xfer({1'b0, a, 8'h00}, d);
  endtask : rd
endmodule : host_spi
`default_nettype wire

// ---- spread_modem_mode_sequencer_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "modem_seq_consts.svh"
// ----------------------------------------
// Bench top
// ----------------------------------------
module spread_modem_mode_sequencer_tb_top
  import modem_seq_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  wire logic   spi_nss_n, spi_sck, spi_mosi;
  logic        spi_miso, spi_miso_oe_n, tx_byte_valid, rx_gain_set;
  demod_ev_t   demod = '0;
  logic [19:0] freq_offset_value = '0;
  logic        tx_byte_req = 1'b0;
  logic        tx_end = 1'b0;
  logic [7:0]  tx_byte, drift_comp_value;
  logic [2:0]  op_mode;
  logic [23:0] carrier_freq_word;
  int          n_fail = 0;
  int          num_checks = 0;
  localparam logic [14:0] SYM = 15'h4000, PRE = 15'h2000, HDR = 15'h1000;
  localparam logic [14:0] PEND = 15'h0004, CRC = 15'h0002, LOST = 15'h0001;
  // Released miso line floats high, never the last bit
  wire logic   miso_pin = spi_miso_oe_n ? 1'b1 : spi_miso;

  initial forever #5 clk_sys = ~clk_sys;

  spread_modem_mode_sequencer spread_modem_mode_sequencer_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .spi_nss_n(spi_nss_n), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
    .demod(demod), .freq_offset_value(freq_offset_value), .tx_byte_req(tx_byte_req),
    .tx_end(tx_end), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .rx_gain_set(rx_gain_set), .op_mode(op_mode), .carrier_freq_word(carrier_freq_word),
    .drift_comp_value(drift_comp_value));
  host_spi host_spi_inst (.clk_sys(clk_sys), .spi_nss_n(spi_nss_n), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_miso(miso_pin));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_spi_inst.wr(a, d);
  endtask : wr
  task automatic rdk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_spi_inst.rd(a, d);
    chk({16'h0, d}, {16'h0, exp});
  endtask : rdk
  // Demodulator event as a one-cycle pulse, then a short gap
  task automatic ev(input logic [14:0] e);
    @(posedge clk_sys) demod <= demod_ev_t'(e);
    @(posedge clk_sys) demod <= '0;
    repeat (3) @(posedge clk_sys);
  endtask : ev
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 20 && op_mode !== m; i++) @(posedge clk_sys) #1;
    chk({21'h0, op_mode}, {21'h0, m});
    repeat (2) @(posedge clk_sys);
  endtask : wait_mode
  task automatic mode(input logic [2:0] m);
    wr(7'h01, {5'h0, m});
    wait_mode(m);
  endtask : mode
  task automatic tend();
    @(posedge clk_sys) tx_end <= 1'b1;
    @(posedge clk_sys) tx_end <= 1'b0;
  endtask : tend
  // Byte answer lands one cycle after the request
  task automatic txb(input logic [7:0] exp);
    @(posedge clk_sys) tx_byte_req <= 1'b1;
    @(posedge clk_sys) tx_byte_req <= 1'b0;
    #1 chk({15'h0, tx_byte_valid, tx_byte}, {16'h1, exp});
    repeat (3) @(posedge clk_sys);
  endtask : txb

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_cfg();
    chk(carrier_freq_word, `RST_CARRIER);
    chk({21'h0, op_mode}, {21'h0, `MODE_STDBY});
    wr(7'h06, 8'h12);
    wr(7'h07, 8'h34);
    wr(7'h08, 8'h56);
    wr(7'h27, 8'hf6);
    chk(carrier_freq_word, 24'h123456);
    chk({16'h0, drift_comp_value}, 24'h0000f6);
    rdk(7'h7f, 8'h00); // Unmapped place reads zero
  endtask : test_cfg
  task automatic test_tx();
    wr(7'h0d, `RST_TX_START);
    wr(7'h00, 8'ha1);
    wr(7'h00, 8'hb2);
    wr(7'h22, 8'h02);
    rdk(7'h0d, 8'h82);
    mode(`MODE_TX);
    txb(8'ha1);
    txb(8'hb2);
    tend();
    wait_mode(`MODE_STDBY);
    wr(7'h12, 8'hf7);
    rdk(7'h12, 8'h08);
    wr(7'h12, 8'h08);
    rdk(7'h12, 8'h00);
    mode(`MODE_TX);
    mode(`MODE_STDBY);
    tend();
    rdk(7'h12, 8'h00);
  endtask : test_tx
  task automatic test_window();
    wr(7'h1e, 8'h00);
    wr(7'h1f, 8'h04);
    mode(`MODE_RX_ONESHOT);
    repeat (3) ev(SYM);
    chk({21'h0, op_mode}, 24'h6);
    ev(SYM);
    wait_mode(`MODE_STDBY);
    rdk(7'h12, 8'h80);
    wr(7'h12, 8'h80);
    mode(`MODE_RX_ONESHOT);
    ev(PRE);
    repeat (6) ev(SYM);
    chk({21'h0, op_mode}, 24'h6);
    ev(LOST);
    wait_mode(`MODE_STDBY);
    rdk(7'h12, 8'h80);
    wr(7'h12, 8'hff);
  endtask : test_window
  task automatic test_packet();
    wr(7'h0f, 8'h10);
    wr(7'h0d, 8'h10);
    @(posedge clk_sys) freq_offset_value <= 20'hfff9c;
    mode(`MODE_RX_ONESHOT);
    // Gain pulse stands for one cycle after the preamble event
    @(posedge clk_sys) demod <= demod_ev_t'(PRE);
    @(posedge clk_sys) demod <= '0;
    #1 chk({23'h0, rx_gain_set}, 24'h1);
    repeat (3) @(posedge clk_sys);
    ev(HDR);
    ev({4'h1, 8'hc5, 3'h0});
    ev({4'h1, 8'h3a, 3'h0});
    ev(PEND | CRC);
    wait_mode(`MODE_STDBY);
    rdk(7'h12, 8'h70);
    rdk(7'h28, 8'h0f);
    rdk(7'h29, 8'hff);
    rdk(7'h2a, 8'h9c);
    chk(carrier_freq_word, 24'h123456);
    rdk(7'h10, 8'h10);
    rdk(7'h13, 8'h02);
    wr(7'h0d, 8'h10);
    rdk(7'h00, 8'hc5);
    rdk(7'h00, 8'h3a);
    wr(7'h12, 8'hff);
  endtask : test_packet
  task automatic test_cont();
    wr(7'h21, 8'h02);
    mode(`MODE_RX_CONT);
    ev(PRE);
    repeat (3) ev(SYM);
    ev(HDR);
    rdk(7'h12, 8'h00);
    // Two packets back to back, then idle symbols past the window
    // One-byte packets keep the buffer far from full
    for (int p = 0; p < 2; p++) begin
      ev(PRE);
      ev(HDR);
      ev({4'h1, 8'(8'h11 * (p + 1)), 3'h0});
      ev(PEND);
    end
    repeat (8) ev(SYM);
    chk({21'h0, op_mode}, 24'h5);
    rdk(7'h12, 8'h50);
    rdk(7'h25, 8'h12);
    rdk(7'h10, 8'h11);
    wr(7'h06, 8'haa);
    chk(carrier_freq_word, 24'h123456);
    mode(`MODE_STDBY);
    wr(7'h0d, 8'h10);
    rdk(7'h00, 8'h11);
    rdk(7'h00, 8'h22);
    mode(`MODE_RX_SYNTH);
    wr(7'h06, 8'h65);
    chk(carrier_freq_word, 24'h653456);
    mode(`MODE_SLEEP);
    rdk(7'h00, 8'h00); // Buffer closed in sleep
    mode(`MODE_STDBY);
    wr(7'h0d, 8'h10);
    rdk(7'h00, 8'h00); // Sleep wiped the buffer
  endtask : test_cont

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    test_cfg();
    test_tx();
    test_window();
    test_packet();
    test_cont();
    give_verdict();
  end
  // Watchdog, well beyond the roughly 160 microseconds the run needs
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
endmodule : spread_modem_mode_sequencer_tb_top
`default_nettype wire
